// file: rtl/mpci_init_ctrl.v
// host sequencer that initialises a tri-speed mac with serial gmii pcs
`timescale 1ns/1ns
`include "mpci_defines.vh"

////////////////////////////////////////////////////////////////////////////
// Contract
// RQ1 - interface select bit 0 chooses serial gmii, clear means gigabit x mode
// RQ2 - bit 1 set makes the pcs follow partner abilities after negotiation
// RQ3 - with bit 1 clear, software writes forced speed and duplex fields
// RQ4 - forced speed at bits 3:2: 00 10M, 01 100M, 10 1G, 11 reserved
// RQ5 - forced speed ignored unless serial gmii on and negotiation config off
// RQ6 - bit 4 gives half duplex at 10/100 in forced serial gmii only
// RQ7 - bit 5 picks phy side when 1, mac side when 0; resets to 0
// RQ8 - clear transmit and receive enables, poll zero before mac changes
// RQ9 - section empty depth minus 16, almost levels 3 and 8
// RQ10 - section full 16 gives cut through, 0 gives store and forward
// RQ11 - address bytes 0..3 in low register, bytes 4..5 in high low half
// RQ12 - frame length 1518, gap 12, pause quanta FFFF
// RQ13 - command word selects 100M full duplex, pad/crc strip, address insert
// RQ14 - soft reset after speed change, poll until device clears it
// RQ15 - set both path enables and poll until both read one
// RQ16 - link timer 1.6 ms: 0D40 at offset 12h and 03 at 13h
// RQ17 - negotiated serial gmii writes 0003 to interface select; the code also writes the user forced fields and role bit 5 there
// RQ18 - pcs control 1140 enables negotiation; bits 6, 8, 13 read only
// RQ19 - pcs control 9140 soft resets; poll until reset bit clears
// RQ20 - phy registers 0..31 reached through dword window 80h..9Fh
// RQ21 - half duplex reported sets command bit 10
// RQ22 - interface select bits 15:6 reserved, read zero, written zero
module mpci_init_ctrl #(
  parameter FIFO_DEPTH = 2048,
  parameter [4:0] PHY_ADDRESS = 5'h0A,
  // station address, value arbitrary; first byte sits in bits 47:40
  parameter [47:0] STATION_ADDRESS = 48'h02_00_00_00_00_01,
  parameter CUT_THROUGH = 1,
  parameter [15:0] POLL_LIMIT = 16'hFFFF
) (
  input wire clock,
  input wire reset_n,
  // user side: whole init sequence
  input wire start,
  input wire serialGmiiSelect,
  input wire useNegotiatedConfig,
  input wire [1:0] forcedSpeed,
  input wire forcedHalfDuplex,
  input wire negotiationRole,
  input wire halfDuplexEnable,
  output wire busy,
  output reg initDone_r,
  output reg initError_r,
  // user side: single phy register access through the window
  input wire phyReq,
  input wire phyWrite,
  input wire [4:0] phyReg,
  input wire [15:0] phyWData,
  output reg [15:0] phyRData_r,
  output reg phyAck_r,
  // device register port
  output reg [7:0] regAddress_r,
  output reg regWrite_r,
  output reg regRead_r,
  output reg [31:0] regWriteData_r,
  input wire [31:0] regReadData,
  input wire regWaitRequest
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_LOAD = 2'h1;
  localparam [1:0] ST_XFER = 2'h2;
  localparam [1:0] ST_PHY = 2'h3;

  localparam [31:0] SECTION_EMPTY = FIFO_DEPTH - `MPCI_SECTION_MARGIN;
  localparam [31:0] SECTION_FULL = (CUT_THROUGH != 0) ?
    `MPCI_CUT_THROUGH_LEVEL : `MPCI_STORE_FORWARD_LEVEL;
  // first byte in the lowest lane of the low register
  localparam [31:0] MAC_LOW_VAL = {STATION_ADDRESS[23:16],
    STATION_ADDRESS[31:24], STATION_ADDRESS[39:32], STATION_ADDRESS[47:40]};
  localparam [31:0] MAC_HIGH_VAL = {16'h0000, STATION_ADDRESS[7:0],
    STATION_ADDRESS[15:8]};

  reg [1:0] state_r;
  reg [4:0] stepIdx_r;
  reg [15:0] pollCnt_r;
  reg stepOp;
  reg [7:0] stepAddr;
  reg [31:0] stepData;
  reg [31:0] stepMask;
  wire [31:0] cmdWord;
  wire [31:0] ifSelWord;
  wire pollMiss;

  ////////////////////////////////////////////////////////////////////////////
  // composed register words

  // pcs must stay at speed/ena10 zero; only half duplex is user steered
  assign cmdWord = `MPCI_CMD_BASE |
    ({31'h0, halfDuplexEnable} << `MPCI_CMD_HALF_DUPLEX_BIT); // RQ21

  // reserved bits stay zero; forced fields always written so the pcs
  // configuration is defined even when it ignores them
  assign ifSelWord = {26'h0, // RQ22
    negotiationRole, // RQ7
    forcedHalfDuplex, // RQ6
    forcedSpeed, // RQ4 RQ5 RQ3
    useNegotiatedConfig, // RQ2 RQ17
    serialGmiiSelect}; // RQ1

  ////////////////////////////////////////////////////////////////////////////
  // sequence table: one write or poll per step

  always @* begin
    stepOp = `MPCI_OP_WRITE;
    stepAddr = 8'h00;
    stepData = 32'h00000000;
    stepMask = 32'h00000000;
    case (stepIdx_r)
      5'd0: begin
        stepAddr = `MPCI_PHY_WINDOW_ADDRESS; // RQ20
        stepData = {27'h0, PHY_ADDRESS};
      end
      5'd1: begin
        stepAddr = `MPCI_PCS_BASE + `MPCI_LINK_TIMER_LOW;
        stepData = `MPCI_LINK_TIMER_LOW_VAL; // RQ16
      end
      5'd2: begin
        stepAddr = `MPCI_PCS_BASE + `MPCI_LINK_TIMER_HIGH;
        stepData = `MPCI_LINK_TIMER_HIGH_VAL; // RQ16
      end
      5'd3: begin
        stepAddr = `MPCI_PCS_BASE + `MPCI_PCS_INTERFACE_SELECT;
        stepData = ifSelWord; // RQ17
      end
      5'd4: begin
        stepAddr = `MPCI_PCS_BASE + `MPCI_PCS_CONTROL;
        stepData = `MPCI_PCS_AN_ENABLE; // RQ18
      end
      5'd5: begin
        stepAddr = `MPCI_PCS_BASE + `MPCI_PCS_CONTROL;
        stepData = `MPCI_PCS_AN_RESET; // RQ19
      end
      5'd6: begin
        stepOp = `MPCI_OP_POLL;
        stepAddr = `MPCI_PCS_BASE + `MPCI_PCS_CONTROL;
        stepMask = `MPCI_PCS_RESET_MASK; // RQ19
      end
      5'd7: begin
        stepAddr = `MPCI_CMD_CONFIG;
        stepData = `MPCI_CMD_DISABLE; // RQ8
      end
      5'd8: begin
        stepOp = `MPCI_OP_POLL;
        stepAddr = `MPCI_CMD_CONFIG;
        stepMask = `MPCI_CMD_PATH_MASK; // RQ8
      end
      5'd9: begin
        stepAddr = `MPCI_TX_SECTION_EMPTY;
        stepData = SECTION_EMPTY; // RQ9
      end
      5'd10: begin
        stepAddr = `MPCI_TX_ALMOST_FULL;
        stepData = `MPCI_TX_ALMOST_FULL_VAL; // RQ9
      end
      5'd11: begin
        stepAddr = `MPCI_TX_ALMOST_EMPTY;
        stepData = `MPCI_ALMOST_LEVEL_VAL; // RQ9
      end
      5'd12: begin
        stepAddr = `MPCI_RX_SECTION_EMPTY;
        stepData = SECTION_EMPTY; // RQ9
      end
      5'd13: begin
        stepAddr = `MPCI_RX_ALMOST_FULL;
        stepData = `MPCI_ALMOST_LEVEL_VAL; // RQ9
      end
      5'd14: begin
        stepAddr = `MPCI_RX_ALMOST_EMPTY;
        stepData = `MPCI_ALMOST_LEVEL_VAL; // RQ9
      end
      5'd15: begin
        stepAddr = `MPCI_TX_SECTION_FULL;
        stepData = SECTION_FULL; // RQ10
      end
      5'd16: begin
        stepAddr = `MPCI_RX_SECTION_FULL;
        stepData = SECTION_FULL; // RQ10
      end
      5'd17: begin
        stepAddr = `MPCI_MAC_ADDR_LOW;
        stepData = MAC_LOW_VAL; // RQ11
      end
      5'd18: begin
        stepAddr = `MPCI_MAC_ADDR_HIGH;
        stepData = MAC_HIGH_VAL; // RQ11
      end
      5'd19: begin
        stepAddr = `MPCI_FRAME_LENGTH;
        stepData = `MPCI_FRAME_LENGTH_VAL; // RQ12
      end
      5'd20: begin
        stepAddr = `MPCI_TX_IPG_LENGTH;
        stepData = `MPCI_TX_IPG_VAL; // RQ12
      end
      5'd21: begin
        stepAddr = `MPCI_PAUSE_QUANTA;
        stepData = `MPCI_PAUSE_QUANTA_VAL; // RQ12
      end
      5'd22: begin
        stepAddr = `MPCI_CMD_CONFIG;
        stepData = cmdWord; // RQ13
      end
      5'd23: begin
        stepAddr = `MPCI_CMD_CONFIG;
        stepData = cmdWord | `MPCI_CMD_SOFT_RESET; // RQ14
      end
      5'd24: begin
        stepOp = `MPCI_OP_POLL;
        stepAddr = `MPCI_CMD_CONFIG;
        stepMask = `MPCI_CMD_SOFT_RESET; // RQ14
      end
      5'd25: begin
        stepAddr = `MPCI_CMD_CONFIG;
        stepData = cmdWord | `MPCI_CMD_PATH_MASK; // RQ15
      end
      default: begin
        stepOp = `MPCI_OP_POLL;
        stepAddr = `MPCI_CMD_CONFIG;
        stepMask = `MPCI_CMD_PATH_MASK;
        stepData = `MPCI_CMD_PATH_MASK; // RQ15
      end
    endcase
  end

  // a poll passes when the masked read equals the expected pattern
  assign pollMiss = (stepOp == `MPCI_OP_POLL) &&
    ((regReadData & stepMask) != stepData);
  assign busy = (state_r != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and register port

  // strobes hold until the device drops wait request
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      stepIdx_r <= 5'd0;
      pollCnt_r <= 16'h0000;
      initDone_r <= 1'b0;
      initError_r <= 1'b0;
      phyRData_r <= 16'h0000;
      phyAck_r <= 1'b0;
      regAddress_r <= 8'h00;
      regWrite_r <= 1'b0;
      regRead_r <= 1'b0;
      regWriteData_r <= 32'h00000000;
    end else begin
      phyAck_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (start) begin
            stepIdx_r <= 5'd0;
            pollCnt_r <= 16'h0000;
            initDone_r <= 1'b0;
            initError_r <= 1'b0;
            state_r <= ST_LOAD;
          end else if (phyReq) begin
            // window offset picks the phy register number
            regAddress_r <= `MPCI_PHY_WINDOW_BASE | {3'b000, phyReg}; // RQ20
            regWrite_r <= phyWrite;
            regRead_r <= ~phyWrite;
            regWriteData_r <= {16'h0000, phyWData};
            state_r <= ST_PHY;
          end
        end
        ST_LOAD: begin
          regAddress_r <= stepAddr;
          regWrite_r <= (stepOp == `MPCI_OP_WRITE);
          regRead_r <= (stepOp == `MPCI_OP_POLL);
          regWriteData_r <= stepData;
          state_r <= ST_XFER;
        end
        ST_XFER: begin
          if (!regWaitRequest) begin
            regWrite_r <= 1'b0;
            regRead_r <= 1'b0;
            if (pollMiss) begin
              // bounded polling so a dead device cannot hang the host
              if (pollCnt_r == POLL_LIMIT) begin
                initError_r <= 1'b1;
                state_r <= ST_IDLE;
              end else begin
                pollCnt_r <= pollCnt_r + 16'h0001;
                state_r <= ST_LOAD;
              end
            end else if (stepIdx_r == `MPCI_LAST_STEP) begin
              initDone_r <= 1'b1;
              state_r <= ST_IDLE;
            end else begin
              stepIdx_r <= stepIdx_r + 5'd1;
              pollCnt_r <= 16'h0000;
              state_r <= ST_LOAD;
            end
          end
        end
        default: begin
          if (!regWaitRequest) begin
            regWrite_r <= 1'b0;
            regRead_r <= 1'b0;
            phyRData_r <= regReadData[15:0];
            phyAck_r <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
      endcase
    end
  end

endmodule

// file: pkg/mpci_defines.vh
// register map of the attached mac/pcs and init sequence constants
`ifndef MPCI_DEFINES_VH
`define MPCI_DEFINES_VH

// dword offsets of the mac register space
`define MPCI_CMD_CONFIG 8'h02
`define MPCI_MAC_ADDR_LOW 8'h03
`define MPCI_MAC_ADDR_HIGH 8'h04
`define MPCI_FRAME_LENGTH 8'h05
`define MPCI_PAUSE_QUANTA 8'h06
`define MPCI_RX_SECTION_EMPTY 8'h07
`define MPCI_RX_SECTION_FULL 8'h08
`define MPCI_TX_SECTION_EMPTY 8'h09
`define MPCI_TX_SECTION_FULL 8'h0A
`define MPCI_RX_ALMOST_EMPTY 8'h0B
`define MPCI_RX_ALMOST_FULL 8'h0C
`define MPCI_TX_ALMOST_EMPTY 8'h0D
`define MPCI_TX_ALMOST_FULL 8'h0E
`define MPCI_PHY_WINDOW_ADDRESS 8'h0F
`define MPCI_TX_IPG_LENGTH 8'h17
// external phy registers 0..31 appear at 0x80..0x9F
`define MPCI_PHY_WINDOW_BASE 8'h80
// pcs register block base and its word offsets
`define MPCI_PCS_BASE 8'hA0
`define MPCI_PCS_CONTROL 8'h00
`define MPCI_LINK_TIMER_LOW 8'h12
`define MPCI_LINK_TIMER_HIGH 8'h13
`define MPCI_PCS_INTERFACE_SELECT 8'h14

// command configuration values and fields
`define MPCI_CMD_BASE 32'h00800220
`define MPCI_CMD_DISABLE 32'h00802220
`define MPCI_CMD_PATH_MASK 32'h00000003
`define MPCI_CMD_SOFT_RESET 32'h00002000
`define MPCI_CMD_HALF_DUPLEX_BIT 10

// pcs interface select fields
`define MPCI_IFS_SERIAL_GMII_BIT 0
`define MPCI_IFS_USE_NEG_BIT 1
`define MPCI_IFS_SPEED_LSB 2
`define MPCI_IFS_HALF_DUPLEX_BIT 4
`define MPCI_IFS_ROLE_BIT 5

// pcs control values
`define MPCI_PCS_AN_ENABLE 32'h00001140
`define MPCI_PCS_AN_RESET 32'h00009140
`define MPCI_PCS_RESET_MASK 32'h00008000

// link timer 1.6 ms
`define MPCI_LINK_TIMER_LOW_VAL 32'h00000D40
`define MPCI_LINK_TIMER_HIGH_VAL 32'h00000003

// fifo and frame settings
`define MPCI_SECTION_MARGIN 16
`define MPCI_CUT_THROUGH_LEVEL 32'h00000010
`define MPCI_STORE_FORWARD_LEVEL 32'h00000000
`define MPCI_TX_ALMOST_FULL_VAL 32'h00000003
`define MPCI_ALMOST_LEVEL_VAL 32'h00000008
`define MPCI_FRAME_LENGTH_VAL 32'h000005EE // 1518 bytes
`define MPCI_TX_IPG_VAL 32'h0000000C // 12 bytes
`define MPCI_PAUSE_QUANTA_VAL 32'h0000FFFF

// sequence length and step kinds
`define MPCI_LAST_STEP 5'h1A
`define MPCI_OP_WRITE 1'b0
`define MPCI_OP_POLL 1'b1

`endif

// file: tb/mpci_init_chk.sv
// port assertions for the mac/pcs init sequencer
`timescale 1ns/1ns
module mpci_init_chk (
  input wire clock,
  input wire reset_n,
  input wire serialGmiiSelect,
  input wire useNegotiatedConfig,
  input wire [1:0] forcedSpeed,
  input wire forcedHalfDuplex,
  input wire negotiationRole,
  input wire halfDuplexEnable,
  input wire initDone_r,
  input wire initError_r,
  input wire [4:0] phyReg,
  input wire phyAck_r,
  input wire [7:0] regAddress_r,
  input wire regWrite_r,
  input wire regRead_r,
  input wire [31:0] regWriteData_r,
  input wire regWaitRequest
);
  // access strobe and decoded write targets
  wire strobe = regWrite_r | regRead_r;
  wire wrIfs = regWrite_r && regAddress_r == 8'hB4;
  wire wrTmr = regWrite_r && regAddress_r[7:1] == 7'h59;
  wire wrPcs = regWrite_r && regAddress_r == 8'hA0;
  wire wrCmd = regWrite_r && regAddress_r == 8'h02;
  wire rstGo = wrPcs && regWriteData_r[15] && !regWaitRequest;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  ifs_word_a: assert property (wrIfs |->
    regWriteData_r == {26'h0, negotiationRole, forcedHalfDuplex, forcedSpeed,
    useNegotiatedConfig, serialGmiiSelect}) else $error("mode word wrong");
  timer_val_a: assert property (wrTmr |->
    regWriteData_r == (regAddress_r[0] ? 32'h3 : 32'hD40))
    else $error("link timer word wrong");
  pcs_ctl_a: assert property (wrPcs |->
    regWriteData_r == 32'h1140 || regWriteData_r == 32'h9140)
    else $error("pcs control word wrong");
  pcs_poll_a: assert property (rstGo |=> !strobe ##1
    regRead_r && regAddress_r == 8'hA0) else $error("no pcs reset poll");
  path_on_a: assert property (wrCmd &&
    regWriteData_r[1:0] == 2'b11 |->
    regWriteData_r == (32'h00800223 | {halfDuplexEnable, 10'h0}))
    else $error("enable word wrong");
  done_src_a: assert property ($rose(initDone_r) |->
    $past(regRead_r) && $past(regAddress_r) == 8'h02)
    else $error("done without command poll");
  err_src_a: assert property ($rose(initError_r) |-> $past(regRead_r))
    else $error("error flag without a poll read");
  bus_hold_a: assert property (strobe && regWaitRequest |=>
    strobe && $stable(regAddress_r) && $stable(regWriteData_r))
    else $error("request changed while stalled");
  win_addr_a: assert property (strobe &&
    regAddress_r[7:5] == 3'b100 |-> regAddress_r[4:0] == phyReg)
    else $error("window address wrong");
  ack_pulse_a: assert property ($rose(phyAck_r) |->
    $past(strobe) ##1 !phyAck_r) else $error("phy ack not a pulse");
endmodule
bind mpci_init_ctrl mpci_init_chk i_mpci_init_chk (.clock, .reset_n,
  .serialGmiiSelect, .useNegotiatedConfig, .forcedSpeed, .forcedHalfDuplex,
  .negotiationRole, .halfDuplexEnable, .initDone_r, .initError_r, .phyReg,
  .phyAck_r, .regAddress_r, .regWrite_r, .regRead_r, .regWriteData_r,
  .regWaitRequest);

// file: tb/mpci_dev_model.sv
// register-space model of the mac/pcs device behind the sequencer
`timescale 1ns/1ns
module mpci_dev_model (
  input wire clock,
  input wire reset_n,
  input wire slow,
  input wire stuckReset,
  input wire [7:0] regAddress,
  input wire regWrite,
  input wire regRead,
  input wire [31:0] regWriteData,
  output wire [1:0] pcsSpeed,
  output wire pcsHalf,
  output wire [31:0] regReadData,
  output wire regWaitRequest
);
  reg [31:0] mem [0:255];
  reg [31:0] last_r;
  reg [1:0] waitCnt_r;
  reg [2:0] macCnt_r;
  reg [2:0] pcsCnt_r;
  integer i;
  wire acc = (regWrite | regRead) & ~regWaitRequest;
  wire [31:0] ifs = mem[8'hB4];
  // effective pcs speed: forced field only in forced serial mode
  // the partner is taken to negotiate gigabit full duplex
  assign pcsSpeed = (ifs[0] && !ifs[1]) ? ifs[3:2] : 2'h2;
  assign pcsHalf = ifs[0] && !ifs[1] && ifs[4] && !ifs[3];
  // slow mode stalls every access two cycles; idle bus shows inverted data
  assign regWaitRequest = slow && (regWrite | regRead) && waitCnt_r != 2'd2;
  assign regReadData = regRead ? mem[regAddress] : ~last_r;
  // storage, self-clearing resets and read-only bits
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (i = 0; i < 256; i = i + 1)
        mem[i] <= 32'h0;
      last_r <= 32'h0;
      waitCnt_r <= 2'd0;
      macCnt_r <= 3'd0;
      pcsCnt_r <= 3'd0;
    end else begin
      waitCnt_r <= regWaitRequest ? waitCnt_r + 2'd1 : 2'd0;
      if (acc && regRead)
        last_r <= regReadData;
      if (macCnt_r != 3'd0 && !stuckReset) begin
        macCnt_r <= macCnt_r - 3'd1;
        if (macCnt_r == 3'd1)
          mem[8'h02][13] <= 1'b0;
      end
      if (pcsCnt_r != 3'd0) begin
        pcsCnt_r <= pcsCnt_r - 3'd1;
        if (pcsCnt_r == 3'd1)
          mem[8'hA0][15] <= 1'b0;
      end
      if (acc && regWrite) begin
        if (regAddress == 8'hB4)
          mem[regAddress] <= regWriteData & 32'h3F;
        else if (regAddress == 8'hA0)
          mem[regAddress] <= regWriteData & ~32'h2140 | 32'h0140;
        else
          mem[regAddress] <= regWriteData;
        if (regAddress == 8'h02)
          macCnt_r <= regWriteData[13] ? 3'd3 : 3'd0;
        if (regAddress == 8'hA0)
          pcsCnt_r <= regWriteData[15] ? 3'd3 : 3'd0;
      end
    end
  end
endmodule

// file: tb/mac_pcs_mode_config_init_tb_top.sv
// self-checking bench for the mac/pcs init sequencer
`timescale 1ns/1ns
module mac_pcs_mode_config_init_tb_top;
  reg clock = 1'b0;
  reg reset_n = 1'b0;
  reg start = 1'b0, serialGmiiSelect = 1'b0, useNegotiatedConfig = 1'b0;
  reg forcedHalfDuplex = 1'b0, negotiationRole = 1'b0, halfDuplexEnable = 1'b0;
  reg phyReq = 1'b0, phyWrite = 1'b0, slow = 1'b0, stuckReset = 1'b0;
  reg [1:0] forcedSpeed = 2'h0;
  reg [4:0] phyReg = 5'h00;
  reg [15:0] phyWData = 16'h0000;
  wire busy, initDone_r, initError_r, phyAck_r, regWrite_r, regRead_r;
  wire regWaitRequest;
  wire pcsHalf;
  wire [1:0] pcsSpeed;
  wire [15:0] phyRData_r;
  wire [7:0] regAddress_r;
  wire [31:0] regWriteData_r, regReadData;
  reg [39:0] expQ[$];
  reg [39:0] exp;
  reg [31:0] r;
  integer errors = 0, checks = 0, t, k;
  mpci_init_ctrl #(.STATION_ADDRESS(48'h0A0B0C0D0E0F), // value arbitrary
    .POLL_LIMIT(16'h0004)) i_mpci_init_ctrl (.clock(clock),
    .reset_n(reset_n), .start(start), .serialGmiiSelect(serialGmiiSelect),
    .useNegotiatedConfig(useNegotiatedConfig), .forcedSpeed(forcedSpeed),
    .forcedHalfDuplex(forcedHalfDuplex), .negotiationRole(negotiationRole),
    .halfDuplexEnable(halfDuplexEnable), .busy(busy),
    .initDone_r(initDone_r), .initError_r(initError_r), .phyReq(phyReq),
    .phyWrite(phyWrite), .phyReg(phyReg), .phyWData(phyWData),
    .phyRData_r(phyRData_r), .phyAck_r(phyAck_r),
    .regAddress_r(regAddress_r), .regWrite_r(regWrite_r),
    .regRead_r(regRead_r), .regWriteData_r(regWriteData_r),
    .regReadData(regReadData), .regWaitRequest(regWaitRequest));
  mpci_dev_model i_mpci_dev_model (.clock(clock), .reset_n(reset_n),
    .slow(slow), .stuckReset(stuckReset), .regAddress(regAddress_r),
    .regWrite(regWrite_r), .regRead(regRead_r),
    .regWriteData(regWriteData_r), .pcsSpeed(pcsSpeed), .pcsHalf(pcsHalf),
    .regReadData(regReadData),
    .regWaitRequest(regWaitRequest));
  always #2 clock = ~clock;
  task automatic check(input string nm, input [31:0] e, input [31:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("ERROR %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // every accepted write is matched against the oldest note
  always @(posedge clock) begin
    if (reset_n && regWrite_r && !regWaitRequest) begin
      exp = expQ.size() ? expQ.pop_front() : 40'hFF_FFFFFFFF;
      check("write", exp, {regAddress_r, regWriteData_r});
      check("write address", exp[39:32], regAddress_r);
    end
  end
  task note(input [7:0] a, input [31:0] d);
    expQ.push_back({a, d});
  endtask
  task wait_idle;
    begin
      k = 0;
      @(posedge clock);
      #1;
      while (busy !== 1'b0 && k < 2000) begin
        @(posedge clock);
        #1;
        k = k + 1;
      end
      check("idle", 0, busy);
    end
  endtask
  task run_init(input s, input st);
    reg [31:0] cmd;
    reg [1:0] sp;
    begin
      r = $urandom;
      sp = r[6:5] % 3;
      cmd = 32'h00800220 | {r[4], 10'h0};
      slow <= s;
      stuckReset <= st;
      {forcedHalfDuplex, useNegotiatedConfig, serialGmiiSelect} <= r[2:0];
      {halfDuplexEnable, negotiationRole} <= r[4:3];
      forcedSpeed <= sp;
      note(8'h0F, 32'h0A);
      note(8'hB2, 32'hD40);
      note(8'hB3, 32'h3);
      note(8'hB4, {26'h0, r[3], r[2], sp, r[1:0]});
      note(8'hA0, 32'h1140);
      note(8'hA0, 32'h9140);
      note(8'h02, 32'h00802220);
      note(8'h09, 32'h7F0);
      note(8'h0E, 32'h3);
      note(8'h0D, 32'h8);
      note(8'h07, 32'h7F0);
      note(8'h0C, 32'h8);
      note(8'h0B, 32'h8);
      note(8'h0A, 32'h10);
      note(8'h08, 32'h10);
      note(8'h03, 32'h0D0C0B0A);
      note(8'h04, 32'h00000F0E);
      note(8'h05, 32'h5EE);
      note(8'h17, 32'hC);
      note(8'h06, 32'hFFFF);
      note(8'h02, cmd);
      note(8'h02, cmd | 32'h2000);
      if (!st)
        note(8'h02, cmd | 32'h3);
      start <= 1'b1;
      @(posedge clock);
      start <= 1'b0;
      wait_idle;
      check("done flag", !st, initDone_r);
      check("error flag", st, initError_r);
      check("notes left", 0, expQ.size());
      // forced fields only count in serial mode without negotiated config
      check("pcs speed", (r[0] && !r[1]) ? sp : 2'h2, pcsSpeed);
      check("pcs half", r[0] && !r[1] && r[2] && !sp[1], pcsHalf);
      @(posedge clock);
    end
  endtask
  task phy(input w, input [4:0] n, input [15:0] d);
    begin
      phyWrite <= w;
      phyReg <= n;
      phyWData <= d;
      phyReq <= 1'b1;
      if (w)
        note({3'b100, n}, {16'h0, d});
      @(posedge clock);
      phyReq <= 1'b0;
      k = 0;
      do begin
        @(posedge clock);
        #1;
        k = k + 1;
      end while (phyAck_r !== 1'b1 && k < 50);
      check("phy ack", 1, phyAck_r);
      if (!w)
        check("phy read", d, phyRData_r);
      @(posedge clock);
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // watchdog far beyond the expected run length
  initial begin
    #100000;
    errors = errors + 1;
    finish_test;
  end
  // main sequence: prompt and stalling device, stuck reset, window access
  initial begin
    r = $urandom(6706);
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    for (t = 0; t < 5; t = t + 1) begin
      run_init(t[0], t == 4);
      $display("init test %0d done", t);
    end
    for (t = 0; t < 2; t = t + 1) begin
      r = $urandom;
      slow <= t[0];
      phy(1'b1, r[4:0], r[31:16]);
      phy(1'b0, r[4:0], r[31:16]);
      $display("phy test %0d done", t);
    end
    finish_test;
  end
endmodule
